// >>> hw/acc_load_consts.vh
// opcodes, widths and register map for the accumulator load decoder
`ifndef ACC_LOAD_CONSTS_VH
`define ACC_LOAD_CONSTS_VH
`define INSN_W 10
`define ACC_W 4
`define SP_W 3
`define OP_LOAD_ADC3 10'h246
`define OP_LOAD_SP 10'h250
`define OP_LOAD_IRQ1 10'h054
`define OP_LOAD_IRQ2 10'h055
`define OP_LOAD_TMR1 10'h24b
`define OP_LOAD_TMR2 10'h24c
`define OP_LOAD_TMR3 10'h24d
`define OP_LOAD_TMR4 10'h24e
`define ADDR_INSN 8'h00
`define ADDR_ACC 8'h04
`define ADDR_SRC_A 8'h08
`define ADDR_SRC_B 8'h0c
`define ADDR_STAT 8'h10
`define ADDR_PC 8'h14
`define SRC_A_RST 32'h0000_0000
`define SRC_B_RST 32'h0000_0000
`define SRC_NIB_RST 4'h0
`define ACC_RST 4'h0
`define PC_RST 16'h0000
`define CARRY_RST 1'b0
`define LANE_SP 3
`define LANE_SP_MASK 4'h7
`define LANE_FULL_MASK 4'hf
`endif

// >>> hw/acc_load_from_ctrl_regs.v
// accumulator load decoder for control-register transfer instructions
// Notes on behaviour
// - opcode 246h loads A from adc_ctrl_third
// - stack_pointer to acc bits 2..0, bit 3 zero
// - opcode 054h loads A from irq_ctrl_first
// - opcode 055h loads A from irq_ctrl_second
// - opcode 24Bh loads A from tmr_ctrl_first
// - opcode 24Ch loads A from tmr_ctrl_second
// - opcode 24Dh loads A from tmr_ctrl_third
// - opcode 24Eh loads A from tmr_ctrl_fourth
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "acc_load_consts.vh"
module acc_load_from_ctrl_regs (
    input wire hclk, // 25 MHz bus clock
    input wire hresetn, // async reset, active low
    input wire hsel, // slave select
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size
    input wire hready, // bus ready
    input wire [31:0] hwdata, // write data
    output reg [31:0] hrdata, // read data
    output wire hreadyout, // always ready
    output wire hresp // always okay
);
    // ==========================================================
    // bus address phase capture
    // an accepted address phase is remembered for exactly the one
    // data phase after it; hsize is not looked at, so narrow
    // accesses behave as whole-word accesses
    reg wr_q;
    reg rd_q;
    reg [7:0] addr_q;
    wire acc_phase;
    assign acc_phase = hsel & hready & htrans[1];

    // no wait states and no error responses: every word is ready
    // in the cycle right after its address phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address and direction of the transfer now in its data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc_phase & hwrite;
            rd_q <= acc_phase & ~hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // ==========================================================
    // data phase write strobes, one per writable word
    // hwdata is only valid in the data phase, so every write acts
    // on the edge that closes it, never on the address phase
    wire exec;
    wire wr_src_a;
    wire wr_src_b;
    wire wr_stat;
    assign exec = wr_q & (addr_q == `ADDR_INSN);
    assign wr_src_a = wr_q & (addr_q == `ADDR_SRC_A);
    assign wr_src_b = wr_q & (addr_q == `ADDR_SRC_B);
    assign wr_stat = wr_q & (addr_q == `ADDR_STAT);

    // ==========================================================
    // source nibbles
    // lanes 0..3 come from word a, lanes 4..7 from word b; the
    // stack pointer lane keeps three bits only, so its unused top
    // bit can never reach the accumulator or read back as one
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1)
        begin : g_src
            reg [`ACC_W-1:0] nib_q;
            wire [`ACC_W-1:0] lane_mask;
            wire [`ACC_W-1:0] lane_word;
            wire lane_wr;
            assign lane_mask = (k == `LANE_SP) ? `LANE_SP_MASK : `LANE_FULL_MASK;
            assign lane_wr = (k < 4) ? wr_src_a : wr_src_b;
            assign lane_word = hwdata[4*(k%4) +: 4];
            // only a bus write moves a source; instructions just look
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    nib_q <= `SRC_NIB_RST;
                else if (lane_wr)
                    nib_q <= lane_word & lane_mask;
            end
        end
    endgenerate

    // named views of the lanes, in the order software packs them
    wire [`ACC_W-1:0] adc_ctrl_third;
    wire [`ACC_W-1:0] irq_ctrl_first;
    wire [`ACC_W-1:0] irq_ctrl_second;
    wire [`SP_W-1:0] stack_pointer;
    wire [`ACC_W-1:0] tmr_ctrl_first;
    wire [`ACC_W-1:0] tmr_ctrl_second;
    wire [`ACC_W-1:0] tmr_ctrl_third;
    wire [`ACC_W-1:0] tmr_ctrl_fourth;
    assign adc_ctrl_third = g_src[0].nib_q;
    assign irq_ctrl_first = g_src[1].nib_q;
    assign irq_ctrl_second = g_src[2].nib_q;
    assign stack_pointer = g_src[3].nib_q[`SP_W-1:0];
    assign tmr_ctrl_first = g_src[4].nib_q;
    assign tmr_ctrl_second = g_src[5].nib_q;
    assign tmr_ctrl_third = g_src[6].nib_q;
    assign tmr_ctrl_fourth = g_src[7].nib_q;

    // ==========================================================
    // architectural state seen by the instructions
    reg [`ACC_W-1:0] acc_q;
    reg [15:0] pc_q;
    reg carry_flag_q;
    reg last_hit_q;
    reg [`ACC_W-1:0] acc_d;
    reg hit;

    // ==========================================================
    // decoder: a pure read of the source, never a side effect
    // an unknown word leaves the accumulator as it is and clears
    // the hit flag, so software can tell a typo from a real load
    always @*
    begin
        acc_d = acc_q;
        hit = 1'b1;
        case (hwdata[`INSN_W-1:0])
            `OP_LOAD_ADC3: acc_d = adc_ctrl_third;
            `OP_LOAD_SP: acc_d = {1'b0, stack_pointer};
            `OP_LOAD_IRQ1: acc_d = irq_ctrl_first;
            `OP_LOAD_IRQ2: acc_d = irq_ctrl_second;
            `OP_LOAD_TMR1: acc_d = tmr_ctrl_first;
            `OP_LOAD_TMR2: acc_d = tmr_ctrl_second;
            `OP_LOAD_TMR3: acc_d = tmr_ctrl_third;
            `OP_LOAD_TMR4: acc_d = tmr_ctrl_fourth;
            default: hit = 1'b0;
        endcase
    end

    // ==========================================================
    // instruction execution
    // one write of the instruction word is one instruction cycle;
    // the program counter steps once per word, decoded or not,
    // so a stray word still moves execution on
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_q <= `ACC_RST;
            pc_q <= `PC_RST;
            last_hit_q <= 1'b0;
        end
        else if (exec)
        begin
            acc_q <= acc_d;
            pc_q <= pc_q + 16'h0001;
            last_hit_q <= hit;
        end
    end

    // ==========================================================
    // carry flag
    // set only by software through the status word; none of these
    // loads touches it, which is what lets a test tell them apart
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            carry_flag_q <= `CARRY_RST;
        else if (wr_stat)
            carry_flag_q <= hwdata[0];
    end

    // ==========================================================
    // read mux
    // combinational from flip-flops so that a read right behind a
    // write sees the new value; the price is a mux on hrdata
    always @*
    begin
        hrdata = 32'h0000_0000;
        if (rd_q)
        begin
            case (addr_q)
                `ADDR_ACC: hrdata = {28'h0, acc_q};
                `ADDR_SRC_A: hrdata = {16'h0, g_src[3].nib_q, irq_ctrl_second,
                    irq_ctrl_first, adc_ctrl_third};
                `ADDR_SRC_B: hrdata = {16'h0, tmr_ctrl_fourth, tmr_ctrl_third,
                    tmr_ctrl_second, tmr_ctrl_first};
                `ADDR_STAT: hrdata = {30'h0, last_hit_q, carry_flag_q};
                `ADDR_PC: hrdata = {16'h0, pc_q};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // limitations
    // the instruction word is taken from hwdata in the data phase
    // only; a master that drives hwdata late will execute whatever
    // stands there at the closing edge. unmapped offsets read zero
    // and ignore writes, and the upper address bits are not decoded,
    // so the whole map repeats every 256 bytes
endmodule // acc_load_from_ctrl_regs

// >>> tb/acc_load_properties.sv
// bus-side assertions for the accumulator load decoder
`timescale 1ns/1ps
`include "acc_load_consts.vh"
module acc_load_checker (
    input wire hclk, // bus clock
    input wire hresetn, // async reset, active low
    input wire hsel, // slave select
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire hready, // bus ready
    input wire [31:0] hwdata, // write data
    input wire [31:0] hrdata, // read data
    input wire hreadyout, // slave ready
    input wire hresp // slave response
);
// ==========================================
// accepted address phases
wire rq = hsel && hready && htrans[1];
wire [7:0] ad = haddr[7:0];
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
ready_high_a: assert property (hreadyout) else $error("slave stalled");
resp_okay_a: assert property (!hresp) else $error("error response");
idle_zero_a: assert property (!$past(rq && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside read phase");
acc_width_a: assert property ($past(rq && !hwrite && ad == 8'h04) |-> hrdata[31:4] == 28'h0)
    else $error("accumulator wider than four bits");
// a stack pointer load followed at once by an accumulator read
sp_top_a: assert property (($past(rq && hwrite && ad == 8'h00) && hwdata[9:0] == `OP_LOAD_SP)
    ##2 $past(rq && !hwrite && ad == 8'h04) |-> hrdata[3] == 1'b0)
    else $error("accumulator top bit set by stack load");
src_a_width_a: assert property ($past(rq && !hwrite && ad == 8'h08) |-> hrdata[31:15] == 17'h0)
    else $error("source word a too wide");
src_b_width_a: assert property ($past(rq && !hwrite && ad == 8'h0c) |-> hrdata[31:16] == 16'h0)
    else $error("source word b too wide");
unmapped_zero_a: assert property ($past(rq && !hwrite && ad == 8'h18) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // acc_load_checker
bind acc_load_from_ctrl_regs acc_load_checker acc_load_checker_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// >>> tb/tb_top.sv
// self-checking bench for the accumulator load decoder
`timescale 1ns/1ps
`include "acc_load_consts.vh"
module tb_top;
// ==========================================
// stimulus, one instance, clock
reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
reg [1:0] htrans = 2'h0;
wire [31:0] hrdata;
wire hreadyout, hresp;
integer fail_count = 0, total_checks = 0, i;
// opcodes and the nibble each one should leave in the accumulator
reg [79:0] ops = {`OP_LOAD_TMR4, `OP_LOAD_TMR3, `OP_LOAD_TMR2, `OP_LOAD_TMR1,
    `OP_LOAD_IRQ2, `OP_LOAD_IRQ1, `OP_LOAD_SP, `OP_LOAD_ADC3};
reg [31:0] exps = 32'hfd96a37c;
acc_load_from_ctrl_regs acc_load_from_ctrl_regs_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
always #20 hclk = ~hclk;
// single word transfer; read data lands in rd at the closing edge
task xfer(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
endtask
task check(input reg [63:0] nm, input reg [31:0] seen, input reg [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
task wrap_up;
    begin
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
// sources loaded first so every opcode picks a distinct nibble
initial
begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, 8'h08, 32'h7a3c);
    xfer(1'b1, 8'h0c, 32'hfd96);
    xfer(1'b1, 8'h10, 32'h1);
    for (i = 0; i < 8; i = i + 1)
    begin
        xfer(1'b1, 8'h00, {22'h0, ops[10*i +: 10]});
        xfer(1'b0, 8'h04, 32'h0);
        check("acc", rd, {28'h0, exps[4*i +: 4]});
    end
    xfer(1'b0, 8'h10, 32'h0);
    check("stat", rd, 32'h3);
    xfer(1'b1, 8'h00, 32'h3ff);
    xfer(1'b0, 8'h04, 32'h0);
    check("acc_keep", rd, 32'hf);
    xfer(1'b0, 8'h10, 32'h0);
    check("miss", rd, 32'h1);
    xfer(1'b0, 8'h08, 32'h0);
    check("src_a", rd, 32'h7a3c);
    xfer(1'b0, 8'h0c, 32'h0);
    check("src_b", rd, 32'hfd96);
    xfer(1'b0, 8'h14, 32'h0);
    check("pc", rd, 32'h9);
    xfer(1'b0, 8'h18, 32'h0);
    check("unmapped", rd, 32'h0);
    wrap_up;
end
// watchdog, far beyond the seventy or so cycles the run needs
initial
begin
    #80000;
    fail_count = fail_count + 1;
    wrap_up;
end
endmodule // tb_top
